// [rtl/sarc_pkg.sv]
// Shared constants and carrier types for the strap address and reset config block
package sarc_pkg;
  // Clock of the block
  localparam int CLK_PERIOD_NS = 50;
  // Write address when every strap is low
  localparam logic [7:0] ADDR_BASE = 8'h30;
  // Strap settle time before sampling, least time
  localparam int STRAP_SETTLE_NS = 1000;
  localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Channel lock time, typical figure
  localparam int LOCK_TIME_US = 15000;
  localparam int LOCK_CYC = LOCK_TIME_US * 1000 / CLK_PERIOD_NS;
  // Reference clock rate expected when the enable is latched high
  localparam int REFCLK_MHZ = 25;
  // Channel enable mask default
  localparam logic [3:0] CH_EN_RST = 4'hf;
  // Revision value, arbitrary
  localparam logic [7:0] REVISION = 8'h06;
  // Number of channels
  localparam int NUM_CH = 4;
  // Bits in one bus address byte
  localparam logic [3:0] ADDR_BITS = 4'h8;

  // Output and enable of a group of two-way pins
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } sarc_strap_drv_s;

  // Output and enable of the open-drain data line
  typedef struct packed {
    logic out;
    logic oe;
  } sarc_sda_drv_s;

  // Differential pair group, one bit per channel
  typedef struct packed {
    logic [3:0] pos;
    logic [3:0] neg;
  } sarc_pair_s;
endpackage

// [rtl/sarc_top.sv]
// Power-up strap capture, soft reset, address match and channel retiming
//
// How it works
// - Straps sampled once per power-up, then held
// - Strap pins then drive channel lock indicators
// - Write address is 0x30 plus twice straps
// - Soft reset restores defaults, restarts channels
// - Refclk enable latched only at power-on
// - Latched enable selects 25 MHz reference
// - Channel n retimes rx n to tx n
// - Fixed read-only revision value exposed
`timescale 1ns/100ps
module sarc_top
  import sarc_pkg::*;
#(
  parameter int LOCK_CYCLES = sarc_pkg::LOCK_CYC
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] addr_strap_in,
  output sarc_pkg::sarc_strap_drv_s strap_drv,
  input wire logic refclk_en_in,
  output logic refclk_25m_sel,
  input wire logic soft_rst,
  input wire logic cfg_wr,
  input wire logic [3:0] cfg_ch_en,
  output logic [3:0] ch_en,
  output logic [7:0] dev_addr,
  output logic [7:0] revision,
  output logic [3:0] ch_lock,
  input wire logic scl_in,
  input wire logic sda_in,
  output sarc_pkg::sarc_sda_drv_s sda_drv,
  output logic addr_hit,
  output logic addr_rw,
  input sarc_pkg::sarc_pair_s rx,
  output sarc_pkg::sarc_pair_s tx
);
  import sarc_pkg::*;
  // Power-up phases
  typedef enum logic {SARC_SETTLE, SARC_RUN} sarc_phase_e;
  // Address receiver states
  typedef enum logic [1:0] {SARC_IDLE, SARC_ADDR, SARC_ACK, SARC_BUSY} sarc_bus_e;
  localparam logic [4:0] SETTLE_LAST = 5'(STRAP_SETTLE_CYC - 1);
  localparam logic [19:0] LOCK_LAST = 20'(LOCK_CYCLES - 1);
  // Two-stage synchronisers for every pin input
  logic [3:0] strap_m, strap_s; // Straps
  logic ren_m, ren_s; // Reference enable
  logic scl_m, scl_s, sda_m, sda_s; // Bus lines
  logic scl_d, sda_d; // Previous synced bus levels
  sarc_pair_s rx_m, rx_s; // Channel inputs

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      strap_m <= 4'h0;
      strap_s <= 4'h0;
      ren_m <= 1'b0;
      ren_s <= 1'b0;
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      rx_m <= '0;
      rx_s <= '0;
    end
    else
    begin
      strap_m <= addr_strap_in;
      strap_s <= strap_m;
      ren_m <= refclk_en_in;
      ren_s <= ren_m;
      scl_m <= scl_in;
      scl_s <= scl_m;
      sda_m <= sda_in;
      sda_s <= sda_m;
      scl_d <= scl_s;
      sda_d <= sda_s;
      rx_m <= rx;
      rx_s <= rx_m;
    end
  end

  // Power-up sequencing and latched configuration
  sarc_phase_e phase, next_phase;
  logic [4:0] settle, next_settle; // Settle counter
  logic [7:0] next_dev_addr;
  logic next_refclk_25m_sel;
  logic [3:0] next_ch_en;

  // Straps and refclk enable are only looked at on leaving settle;
  // soft reset does not touch them, only power-on does
  always_comb
  begin
    next_phase = phase;
    next_settle = settle;
    next_dev_addr = dev_addr;
    next_refclk_25m_sel = refclk_25m_sel;
    next_ch_en = ch_en;
    unique case (phase)
      SARC_SETTLE:
      begin
        next_settle = settle + 5'h1;
        if (settle == SETTLE_LAST)
        begin
          next_phase = SARC_RUN;
          next_dev_addr = ADDR_BASE + {3'h0, strap_s, 1'b0};
          next_refclk_25m_sel = ren_s;
        end
      end
      SARC_RUN: next_settle = settle; // Held once running
    endcase
    // Soft reset beats a same-cycle write
    if (soft_rst)
      next_ch_en = CH_EN_RST;
    else if (cfg_wr)
      next_ch_en = cfg_ch_en;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      phase <= SARC_SETTLE;
      settle <= 5'h0;
      dev_addr <= ADDR_BASE;
      refclk_25m_sel <= 1'b0;
      ch_en <= CH_EN_RST;
      revision <= REVISION;
    end
    else
    begin
      phase <= next_phase;
      settle <= next_settle;
      dev_addr <= next_dev_addr;
      refclk_25m_sel <= next_refclk_25m_sel;
      ch_en <= next_ch_en;
      revision <= REVISION;
    end
  end

  // Per-channel lock counting and retiming
  logic [19:0] lock_cnt [NUM_CH];
  logic [19:0] next_lock_cnt [NUM_CH];
  logic [3:0] next_ch_lock;
  sarc_pair_s next_tx;
  sarc_strap_drv_s next_strap_drv;

  // A channel counts while its pair differs; loss or disable restarts it.
  // Real clock recovery is not modelled, only its restart behaviour.
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      next_lock_cnt[i] = lock_cnt[i];
      next_ch_lock[i] = ch_lock[i];
      if (soft_rst || !ch_en[i] || (rx_s.pos[i] == rx_s.neg[i]))
      begin
        next_lock_cnt[i] = 20'h0;
        next_ch_lock[i] = 1'b0;
      end
      else if (lock_cnt[i] == LOCK_LAST)
        next_ch_lock[i] = 1'b1;
      else
        next_lock_cnt[i] = lock_cnt[i] + 20'h1;
      // Only pair i feeds tx i; muted until locked
      next_tx.pos[i] = ch_lock[i] & rx_s.pos[i];
      next_tx.neg[i] = ch_lock[i] & rx_s.neg[i];
    end
    // Pins stay inputs during settle so the straps are not fought
    next_strap_drv.oe = (phase == SARC_RUN) ? 4'hf : 4'h0;
    next_strap_drv.out = (phase == SARC_RUN) ? ch_lock : 4'h0;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_CH; i++)
        lock_cnt[i] <= 20'h0;
      ch_lock <= 4'h0;
      tx <= '0;
      strap_drv <= '0;
    end
    else
    begin
      lock_cnt <= next_lock_cnt;
      ch_lock <= next_ch_lock;
      tx <= next_tx;
      strap_drv <= next_strap_drv;
    end
  end

  // Address byte receiver on the management bus
  sarc_bus_e bus, next_bus;
  logic [7:0] shift, next_shift; // Incoming address byte
  logic [3:0] nbits, next_nbits; // Bits taken so far
  sarc_sda_drv_s next_sda_drv;
  logic next_addr_hit, next_addr_rw;
  logic start_ev, stop_ev, scl_rise, scl_fall;

  assign start_ev = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_ev = scl_s & scl_d & ~sda_d & sda_s;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;

  // Once running, start or stop always resynchronise, even mid-byte
  always_comb
  begin
    next_bus = bus;
    next_shift = shift;
    next_nbits = nbits;
    next_sda_drv = sda_drv;
    next_addr_hit = 1'b0;
    next_addr_rw = addr_rw;
    if (phase != SARC_RUN)
      next_bus = SARC_IDLE; // No answer before the address is known
    else if (start_ev)
    begin
      next_bus = SARC_ADDR;
      next_nbits = 4'h0;
      next_sda_drv = '0;
    end
    else if (stop_ev)
    begin
      next_bus = SARC_IDLE;
      next_sda_drv = '0;
    end
    else
    begin
      unique case (bus)
        SARC_IDLE: next_bus = SARC_IDLE;
        SARC_ADDR:
        begin
          if (scl_rise)
          begin
            next_shift = {shift[6:0], sda_s};
            next_nbits = nbits + 4'h1;
          end
          else if (scl_fall && nbits == ADDR_BITS)
          begin
            if (shift[7:1] == dev_addr[7:1])
            begin
              next_bus = SARC_ACK;
              next_sda_drv.out = 1'b0; // Pull low to acknowledge
              next_sda_drv.oe = 1'b1;
              next_addr_hit = 1'b1;
              next_addr_rw = shift[0];
            end
            else
              next_bus = SARC_BUSY; // Not ours, stay silent
          end
        end
        SARC_ACK:
        begin
          if (scl_fall)
          begin
            next_bus = SARC_BUSY;
            next_sda_drv = '0; // Release after the ninth clock
          end
        end
        SARC_BUSY: next_bus = SARC_BUSY; // Wait for stop or restart
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      bus <= SARC_IDLE;
      shift <= 8'h00;
      nbits <= 4'h0;
      sda_drv <= '0;
      addr_hit <= 1'b0;
      addr_rw <= 1'b0;
    end
    else
    begin
      bus <= next_bus;
      shift <= next_shift;
      nbits <= next_nbits;
      sda_drv <= next_sda_drv;
      addr_hit <= next_addr_hit;
      addr_rw <= next_addr_rw;
    end
  end
endmodule // sarc_top

// [sim/sarc_props.sv]
// Port checker for the strap address and reset config block
`timescale 1ns/100ps
module sarc_props
  import sarc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] addr_strap_in,
  input wire sarc_pkg::sarc_strap_drv_s strap_drv,
  input wire logic refclk_en_in,
  input wire logic refclk_25m_sel,
  input wire logic soft_rst,
  input wire logic cfg_wr,
  input wire logic [3:0] cfg_ch_en,
  input wire logic [3:0] ch_en,
  input wire logic [7:0] dev_addr,
  input wire logic [7:0] revision,
  input wire logic [3:0] ch_lock,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire sarc_pkg::sarc_sda_drv_s sda_drv,
  input wire logic addr_hit,
  input wire logic addr_rw,
  input wire sarc_pkg::sarc_pair_s rx,
  input wire sarc_pkg::sarc_pair_s tx
);
  // One domain, so clock and reset are given once
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  rev_fixed_a: assert property (revision == REVISION) else $error("revision");
  addr_form_a: assert property (!dev_addr[0] && dev_addr >= 8'h30 && dev_addr <= 8'h4e)
    else $error("address form");
  // Once pins turn to outputs the sampled values must freeze
  addr_hold_a: assert property (strap_drv.oe[0] |-> $stable(dev_addr)) else $error("addr");
  refclk_hold_a: assert property (strap_drv.oe[0] |-> $stable(refclk_25m_sel))
    else $error("refclk select");
  // Registered copy of lock may lag by one cycle
  lock_pins_a: assert property (strap_drv.oe == 4'hf |->
    (strap_drv.out == ch_lock || strap_drv.out == $past(ch_lock))) else $error("lock pins");
  soft_clear_a: assert property (soft_rst |=> ch_en == 4'hf && ch_lock == 4'h0)
    else $error("soft reset");
  cfg_take_a: assert property (cfg_wr && !soft_rst |=> ch_en == $past(cfg_ch_en))
    else $error("enable write");
  tx_follow_a: assert property (ch_lock == 4'hf && $past(ch_lock) == 4'hf |->
    tx == $past(rx, 3)) else $error("retimed data");
  ack_low_a: assert property (sda_drv.oe |-> !sda_drv.out) else $error("sda drive");
  hit_pulse_a: assert property (addr_hit |=> !addr_hit) else $error("hit pulse");
endmodule // sarc_props

// [sim/sarc_host.sv]
// Board controller model: supply sequencing, strap switches, bus host
`timescale 1ns/100ps
module sarc_host
  import sarc_pkg::*;
(
  input wire logic ref_clk,
  input wire sarc_pkg::sarc_strap_drv_s strap_drv,
  input wire sarc_pkg::sarc_sda_drv_s sda_drv,
  output logic rst,
  output logic [3:0] addr_strap_in,
  output logic refclk_en_in,
  output logic scl_in,
  output logic sda_in
);
  logic [3:0] sw; // Switch settings behind the strap pins
  logic sda_lo; // Host pulls data low
  logic [7:0] rec_addr; // Write address noted at power-up
  // Device drive beats the switch resistors
  assign addr_strap_in = (strap_drv.oe & strap_drv.out) | (~strap_drv.oe & sw);
  // Pull-up: low when either side pulls
  assign sda_in = !(sda_lo || (sda_drv.oe && !sda_drv.out));
  initial
  begin
    rst = 1;
    sw = 0;
    refclk_en_in = 0;
    scl_in = 1;
    sda_lo = 0;
    rec_addr = 8'h30;
  end
  // Supply off, set pins, supply on
  task power_up(input logic [3:0] s, input logic r);
    @(negedge ref_clk);
    rst = 1;
    sw = s;
    refclk_en_in = r;
    repeat (4) @(negedge ref_clk);
    rst = 0;
    rec_addr = 8'h30 + {3'h0, s, 1'b0};
  endtask
  // Start, address byte, ack clock, stop; clock idles high between frames
  task send_byte(input logic [7:0] b, output logic ack);
    int i;
    #13 sda_lo = 1;
    #200;
    for (i = 8; i >= 0; i--)
    begin
      scl_in = 0;
      #100 sda_lo = (i > 0) ? !b[i-1] : 1'b0;
      #100 scl_in = 1;
      #100 ack = !sda_in;
      #100;
    end
    scl_in = 0;
    #100 sda_lo = 1;
    #100 scl_in = 1;
    #100 sda_lo = 0;
    #200;
  endtask
endmodule // sarc_host

// [sim/test_sarc_top.sv]
// Self-checking bench for the strap address and reset config block
`timescale 1ns/100ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected %s exp %h got %h", n, e, a); end end
module test_sarc_top;
  import sarc_pkg::*;
  localparam int LOCK_N = 16; // Short lock time keeps the run brief
  logic ref_clk, rst, refclk_en_in, scl_in, sda_in, soft_rst, cfg_wr, ack;
  logic refclk_25m_sel, addr_hit, addr_rw;
  logic [3:0] addr_strap_in, cfg_ch_en, ch_en, ch_lock, s;
  logic [7:0] dev_addr, revision, lfsr;
  sarc_strap_drv_s strap_drv;
  sarc_sda_drv_s sda_drv;
  sarc_pair_s rx, tx;
  int fail_count, comparisons, i, k, hits;
  sarc_top #(.LOCK_CYCLES(LOCK_N)) dut (.ref_clk, .rst, .addr_strap_in, .strap_drv,
    .refclk_en_in, .refclk_25m_sel, .soft_rst, .cfg_wr, .cfg_ch_en, .ch_en, .dev_addr,
    .revision, .ch_lock, .scl_in, .sda_in, .sda_drv, .addr_hit, .addr_rw, .rx, .tx);
  sarc_host host (.ref_clk, .strap_drv, .sda_drv, .rst, .addr_strap_in, .refclk_en_in,
    .scl_in, .sda_in);
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [7:0] exp_addr(input logic [3:0] v);
    return 8'h30 + {3'h0, v, 1'b0};
  endfunction
  // Count acknowledged address bytes; each pulse spans one falling edge
  always @(negedge ref_clk)
    if (addr_hit === 1'b1)
      hits++;
  task stop_test();
    if (fail_count == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Random differential data, then held so delayed output can be compared
  task run_rx(input int n);
    repeat (n)
    begin
      @(negedge ref_clk);
      lfsr = nxt(lfsr);
      rx = {lfsr[3:0], ~lfsr[3:0]};
    end
    repeat (6) @(negedge ref_clk);
  endtask
  initial
  begin
    ref_clk = 0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial
  begin
    lfsr = 8'h0c;
    soft_rst = 0;
    cfg_wr = 0;
    cfg_ch_en = 0;
    rx = 0;
    fail_count = 0;
    comparisons = 0;
    hits = 0;
    // Corners 0 and 15, then a random strap setting, each after a power cycle
    for (i = 0; i < 3; i++)
    begin
      s = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : lfsr[3:0];
      host.power_up(s, lfsr[4]);
      for (k = 0; k < 100 && strap_drv.oe !== 4'hf; k++) @(negedge ref_clk);
      if (k == 100)
      begin
        fail_count++;
        stop_test();
      end
      `CHK("dev_addr", exp_addr(s), dev_addr)
      `CHK("refclk_sel", lfsr[4], refclk_25m_sel)
      `CHK("revision", REVISION, revision)
      `CHK("default_en", CH_EN_RST, ch_en)
      if (i == 1)
      begin
        // Stored settings written back after power-up
        cfg_wr = 1;
        cfg_ch_en = 4'h5;
        @(negedge ref_clk);
        cfg_wr = 0;
        `CHK("reload_en", 4'h5, ch_en)
      end
      host.sw = ~s;
      host.refclk_en_in = ~lfsr[4];
      repeat (5) @(negedge ref_clk);
      `CHK("addr_held", exp_addr(s), dev_addr)
      `CHK("refclk_held", lfsr[4], refclk_25m_sel)
      host.send_byte(host.rec_addr, ack);
      `CHK("wr_ack", 1'b1, ack)
      `CHK("wr_dir", 1'b0, addr_rw)
      `CHK("wr_hit", 2 * i + 1, hits)
      host.send_byte(host.rec_addr + 8'h01, ack);
      `CHK("rd_ack", 1'b1, ack)
      `CHK("rd_dir", 1'b1, addr_rw)
      `CHK("rd_hit", 2 * i + 2, hits)
      host.send_byte(host.rec_addr ^ 8'h80, ack);
      `CHK("miss_ack", 1'b0, ack)
      `CHK("miss_hit", 2 * i + 2, hits)
      lfsr = nxt(lfsr);
    end
    run_rx(LOCK_N + 8);
    `CHK("ch_lock", 4'hf, ch_lock)
    `CHK("tx", rx, tx)
    `CHK("lock_pins", 4'hf, strap_drv.out)
    cfg_wr = 1;
    cfg_ch_en = lfsr[7:4];
    @(negedge ref_clk);
    cfg_wr = 0;
    run_rx(2);
    `CHK("ch_en", cfg_ch_en, ch_en)
    `CHK("muted", {rx.pos & cfg_ch_en, rx.neg & cfg_ch_en}, tx)
    // Soft reset beats a write in the same cycle
    soft_rst = 1;
    cfg_wr = 1;
    cfg_ch_en = 4'h0;
    @(negedge ref_clk);
    soft_rst = 0;
    cfg_wr = 0;
    `CHK("soft_en", 4'hf, ch_en)
    `CHK("soft_lock", 4'h0, ch_lock)
    run_rx(LOCK_N + 8);
    `CHK("relock", 4'hf, ch_lock)
    stop_test();
  end
endmodule // test_sarc_top
bind sarc_top sarc_props props (.ref_clk, .rst, .addr_strap_in, .strap_drv, .refclk_en_in,
  .refclk_25m_sel, .soft_rst, .cfg_wr, .cfg_ch_en, .ch_en, .dev_addr, .revision, .ch_lock,
  .scl_in, .sda_in, .sda_drv, .addr_hit, .addr_rw, .rx, .tx);
